// ==== verilog/sqd_pkg.sv ====
// constants, table and types shared by the quadrature decoder files
package sqd_pkg;
   // register byte addresses
   localparam logic [7:0] SQD_OFF_CTRL   = 8'h00;
   localparam logic [7:0] SQD_OFF_STATUS = 8'h04;
   localparam logic [7:0] SQD_OFF_COUNT  = 8'h08;
   localparam logic [7:0] SQD_OFF_REF    = 8'h0C;
   // control field positions
   localparam int SQD_CTRL_EN    = 0;
   localparam int SQD_CTRL_ENP   = 1;
   localparam int SQD_CTRL_ENM   = 2;
   localparam int SQD_CTRL_ERREN = 3;
   localparam int SQD_CTRL_Q7EN  = 4;
   localparam int SQD_CTRL_MODE  = 5;
   localparam int SQD_CTRL_COMMON = 7;
   localparam int SQD_CTRL_W     = 8;
   localparam logic [SQD_CTRL_W-1:0] SQD_CTRL_RST = 8'h00;
   localparam logic [7:0] SQD_REF_RST = 8'h00;
   // status field positions
   localparam int SQD_ST_ERR   = 0;
   localparam int SQD_ST_STATE = 8;
   localparam int SQD_ST_INDEX = 16;
   // state byte bit positions
   localparam int SQD_Q_LOW  = 0;
   localparam int SQD_Q_INC  = 1;
   localparam int SQD_Q_DEC  = 2;
   localparam int SQD_Q_HIGH = 3;
   localparam int SQD_Q_ERR  = 6;
   localparam int SQD_Q_7    = 7;
   localparam logic [7:0] SQD_STATE_RST = 8'h00;
   // divider settle time for resistive sensors
   localparam int SQD_SETTLE_NS  = 500;
   localparam int SQD_CLK_NS     = 25;
   localparam int SQD_SETTLE_CYC = (SQD_SETTLE_NS + SQD_CLK_NS - 1) / SQD_CLK_NS;
   // quadrature table, index {pair_index_high, pair_index_low, sensor_result_b, sensor_result_a}
   localparam logic [7:0] SQD_TABLE [16] = '{
      8'h00, 8'h03, 8'h0C, 8'h49,
      8'h00, 8'h01, 8'h48, 8'h09,
      8'h00, 8'h41, 8'h08, 8'h09,
      8'h40, 8'h01, 8'h08, 8'h09};
   typedef enum logic [1:0] {
      SQD_MODE_OSC,
      SQD_MODE_RES,
      SQD_MODE_ENV,
      SQD_MODE_RSVD
   } sqd_mode_t;
   typedef enum logic {
      SQD_BUS_IDLE,
      SQD_BUS_RDWAIT
   } sqd_bus_t;
endpackage

// ==== verilog/sqd_psm_if.sv ====
// link between bus top and processing_state_machine
`timescale 1ns/10ps
interface sqd_step_if;
   logic       run;
   logic       step;
   logic [1:0] pair;
   logic       err_mark_en;
   logic       q7_en;
   logic [7:0] state;
   logic [7:0] index;
   logic       inc;
   logic       dec;
   logic       err;
   modport fsm (input run, step, pair, err_mark_en, q7_en, output state, index, inc, dec, err);
   modport ctl (output run, step, pair, err_mark_en, q7_en, input state, index, inc, dec, err);
endinterface

// ==== verilog/sqd_psm.sv ====
// processing_state_machine: table step, state byte and marker pulses
`timescale 1ns/10ps
module sqd_step_fsm (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // link to top
   sqd_step_if.fsm  p
);
   import sqd_pkg::*;

   logic [7:0] state_q;
   logic [7:0] state_d;
   logic       inc_q;
   logic       dec_q;
   logic       err_q;
   wire  logic [7:0] index_w;
   wire  logic [7:0] entry_w;
   wire  logic       err_use_w;
   wire  logic       q7_use_w;

   assign err_use_w = p.err_mark_en & state_q[SQD_Q_ERR];               // [RQ10]
   assign q7_use_w = p.err_mark_en & p.q7_en & state_q[SQD_Q_7];        // [RQ10]
   assign index_w  = {q7_use_w, err_use_w, state_q[5:4], state_q[SQD_Q_HIGH],
                      state_q[SQD_Q_LOW], p.pair};                      // [RQ1] [RQ10]
   assign entry_w  = SQD_TABLE[index_w[3:0]];                           // [RQ2] [RQ3] [RQ4] [RQ5]
   assign state_d  = p.step ? entry_w : state_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= SQD_STATE_RST;                                      // [RQ13]
         inc_q   <= 1'b0;
         dec_q   <= 1'b0;
         err_q   <= 1'b0;
      end else if (!p.run) begin
         state_q <= SQD_STATE_RST;                                      // [RQ13]
         inc_q   <= 1'b0;
         dec_q   <= 1'b0;
         err_q   <= 1'b0;
      end else begin
         state_q <= state_d;                                            // [RQ1]
         inc_q   <= p.step & entry_w[SQD_Q_INC];
         dec_q   <= p.step & entry_w[SQD_Q_DEC];
         err_q   <= p.step & entry_w[SQD_Q_ERR];
      end
   end

   assign p.state = state_q;
   assign p.index = index_w;
   assign p.inc   = inc_q;
   assign p.dec   = dec_q;
   assign p.err   = err_q;

   skip_error_a: assert property (@(posedge hclk) disable iff (!hresetn)   // [RQ3]
      p.run && p.step && (state_q[SQD_Q_HIGH] != state_q[SQD_Q_LOW]) == 1'b0
      && p.pair == ~{state_q[SQD_Q_HIGH], state_q[SQD_Q_LOW]}
      |=> p.err && state_q[SQD_Q_ERR])
      else $error("skipped pair did not mark error");
   full_turn_a: assert property (@(posedge hclk) disable iff (!hresetn)    // [RQ4]
      p.run && p.step && index_w[3:0] == 4'h1 |=> p.inc && !p.dec && state_q == 8'h03)
      else $error("00 to 01 did not increment");
   pair_kept_a: assert property (@(posedge hclk) disable iff (!hresetn)    // [RQ5]
      p.run && p.step |=> {state_q[SQD_Q_HIGH], state_q[SQD_Q_LOW]} == $past(p.pair))
      else $error("state byte lost present pair");
   no_step_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RQ1]
      p.run && !p.step |=> $stable(state_q) && !p.inc && !p.dec && !p.err)
      else $error("state moved without step");
endmodule // sqd_step_fsm

// ==== verilog/sqd_top.sv ====
// quadrature decoder top: ahb-lite registers, sensor front end, counter, error flag
`timescale 1ns/10ps
// How it works
// [RQ1] keep previous sensor pair; direction comes from previous versus present pair
// [RQ2] from pair 00 only 01 or 10 are legal; staying 00 is no rotation
// [RQ3] neighbour-skipping pair changes load a state byte with the error marker set
// [RQ4] count only 00 to 01 (increment) and 00 to 10 (decrement)
// [RQ5] state byte stores present pair in its two index bits for next lookup
// [RQ6] oscillation test: any comparator pulse above reference sets the result bit
// [RQ7] envelope test: comparators go to timer capture outputs; decoder does not step
// [RQ8] per-sensor inputs get own reference level; common input uses one level
// [RQ9] resistive: result is comparator level; divider switched off after settling
// [RQ10] next index from state bits 0 and 3-5, optionally 6 and 7, plus pair
// [RQ11] counter up on increment marker, down on decrement, unchanged when both
// [RQ12] entering a state with error marker sets a flag that software clears
// [RQ13] after reset the decoder starts at index zero with nothing pending
module sqd_top (
   // ahb-lite slave
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // comparator and sequence pins
   input  wire logic        comp_a_pin,
   input  wire logic        comp_b_pin,
   input  wire logic        seq_start_pin,
   input  wire logic        seq_end_pin,
   // analog_front_end and timer outputs
   output logic      [7:0]  ref_level_a,
   output logic      [7:0]  ref_level_b,
   output logic             capture_a,
   output logic             capture_b,
   output logic             divider_on,
   output logic             error_state_flag
);
   import sqd_pkg::*;

   sqd_step_if p ();
   sqd_step_fsm sqd_step_fsm_i (.hclk(hclk), .hresetn(hresetn), .p(p));

   // bus and register state
   sqd_bus_t              bus_q;
   logic [7:0]            addr_q;
   logic                  wr_pend_q;
   logic [31:0]           hrdata_q;
   logic                  hready_q;
   logic [SQD_CTRL_W-1:0] ctrl_q;
   logic [7:0]            ref_a_q;
   logic [7:0]            ref_b_q;
   logic [7:0]            up_down_counter_q;
   logic [7:0]            up_down_counter_d;
   logic                  err_flag_q;
   // front end state
   logic [3:0]            sync1_q;
   logic [3:0]            sync2_q;
   logic [3:0]            sync3_q;
   logic [1:0]            osc_latch_q;
   logic [7:0]            out_ref_a_q;
   logic [7:0]            out_ref_b_q;
   logic                  cap_a_q;
   logic                  cap_b_q;
   logic                  div_q;
   logic [7:0]            settle_q;

   wire logic [3:0]  pins_w = {seq_end_pin, seq_start_pin, comp_b_pin, comp_a_pin};
   wire logic        accept_w = hsel & hready & htrans[1];
   wire logic        wr_ctrl_w = wr_pend_q & (addr_q == SQD_OFF_CTRL);
   wire logic        wr_stat_w = wr_pend_q & (addr_q == SQD_OFF_STATUS);
   wire logic        wr_ref_w  = wr_pend_q & (addr_q == SQD_OFF_REF);
   wire sqd_mode_t   mode_w    = sqd_mode_t'(ctrl_q[SQD_CTRL_MODE +: 2]);
   wire logic        run_w     = ctrl_q[SQD_CTRL_EN];
   wire logic        env_w     = (mode_w == SQD_MODE_ENV);
   wire logic        step_w    = run_w & ~env_w & sync3_q[3] & ~sync2_q[3]; // [RQ7]
   wire logic        start_w   = sync2_q[2] & ~sync3_q[2];
   wire logic [1:0]  comp_w    = sync2_q[1:0];
   wire logic [1:0]  pair_w    = (mode_w == SQD_MODE_OSC) ? (osc_latch_q | comp_w)
                                                          : comp_w;          // [RQ6] [RQ9]
   wire logic        up_w      = p.inc & ctrl_q[SQD_CTRL_ENP];
   wire logic        dn_w      = p.dec & ctrl_q[SQD_CTRL_ENM];
   wire logic [31:0] rd_mux_w  =
      (addr_q == SQD_OFF_CTRL)   ? {24'h000000, ctrl_q} :
      (addr_q == SQD_OFF_STATUS) ? {8'h00, p.index, p.state, 7'h00, err_flag_q} :
      (addr_q == SQD_OFF_COUNT)  ? {24'h000000, up_down_counter_q} :
      (addr_q == SQD_OFF_REF)    ? {16'h0000, ref_b_q, ref_a_q} : 32'h00000000;

   assign p.run   = run_w;
   assign p.step  = step_w;
   assign p.pair  = pair_w;                                                  // [RQ1]
   assign p.err_mark_en = ctrl_q[SQD_CTRL_ERREN];
   assign p.q7_en = ctrl_q[SQD_CTRL_Q7EN];

   always_comb begin
      up_down_counter_d = up_down_counter_q;
      if (up_w && !dn_w)
         up_down_counter_d = up_down_counter_q + 8'h01;                      // [RQ11]
      else if (dn_w && !up_w)
         up_down_counter_d = up_down_counter_q - 8'h01;                      // [RQ11]
   end

   // bus slave: writes zero-wait, reads one wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_q     <= SQD_BUS_IDLE;
         addr_q    <= 8'h00;
         wr_pend_q <= 1'b0;
         hrdata_q  <= 32'h00000000;
         hready_q  <= 1'b1;
      end else begin
         case (bus_q)
            SQD_BUS_IDLE: begin
               wr_pend_q <= accept_w & hwrite;
               if (accept_w)
                  addr_q <= {haddr[7:2], 2'b00};
               if (accept_w && !hwrite) begin
                  bus_q    <= SQD_BUS_RDWAIT;
                  hready_q <= 1'b0;
               end
            end
            SQD_BUS_RDWAIT: begin
               wr_pend_q <= 1'b0;
               hrdata_q  <= rd_mux_w;
               hready_q  <= 1'b1;
               bus_q     <= SQD_BUS_IDLE;
            end
            default: begin
               bus_q    <= SQD_BUS_IDLE;
               hready_q <= 1'b1;
            end
         endcase
      end
   end

   // registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q            <= SQD_CTRL_RST;
         ref_a_q           <= SQD_REF_RST;
         ref_b_q           <= SQD_REF_RST;
         up_down_counter_q <= 8'h00;
         err_flag_q        <= 1'b0;
      end else begin
         if (wr_ctrl_w)
            ctrl_q <= hwdata[SQD_CTRL_W-1:0];
         if (wr_ref_w) begin
            ref_a_q <= hwdata[7:0];
            ref_b_q <= hwdata[15:8];
         end
         up_down_counter_q <= run_w ? up_down_counter_d : 8'h00;
         err_flag_q <= p.err | (err_flag_q & ~(wr_stat_w & hwdata[SQD_ST_ERR])); // [RQ12]
      end
   end

   // pin synchronisers
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               sync1_q[gi] <= 1'b0;
               sync2_q[gi] <= 1'b0;
               sync3_q[gi] <= 1'b0;
            end else begin
               sync1_q[gi] <= pins_w[gi];
               sync2_q[gi] <= sync1_q[gi];
               sync3_q[gi] <= sync2_q[gi];
            end
         end
      end
   endgenerate

   // front end: pulse latch, reference, capture routing, divider timing
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         osc_latch_q <= 2'b00;
         out_ref_a_q <= SQD_REF_RST;
         out_ref_b_q <= SQD_REF_RST;
         cap_a_q     <= 1'b0;
         cap_b_q     <= 1'b0;
         div_q       <= 1'b0;
         settle_q    <= 8'h00;
      end else begin
         osc_latch_q <= comp_w | (osc_latch_q & {2{~step_w}});             // [RQ6]
         out_ref_a_q <= ref_a_q;
         out_ref_b_q <= ctrl_q[SQD_CTRL_COMMON] ? ref_a_q : ref_b_q;        // [RQ8]
         cap_a_q     <= env_w & comp_w[0];                                  // [RQ7]
         cap_b_q     <= env_w & comp_w[1];                                  // [RQ7]
         if (start_w && mode_w == SQD_MODE_RES) begin
            div_q    <= 1'b1;                                               // [RQ9]
            settle_q <= 8'(SQD_SETTLE_CYC);
         end else if (settle_q != 8'h00) begin
            settle_q <= settle_q - 8'h01;
         end else begin
            div_q    <= 1'b0;                                               // [RQ9]
         end
      end
   end

   assign hrdata           = hrdata_q;
   assign hreadyout        = hready_q;
   assign hresp            = 1'b0;
   assign ref_level_a      = out_ref_a_q;
   assign ref_level_b      = out_ref_b_q;
   assign capture_a        = cap_a_q;
   assign capture_b        = cap_b_q;
   assign divider_on       = div_q;
   assign error_state_flag = err_flag_q;

   err_flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn)  // [RQ12]
      p.err |=> err_flag_q)
      else $error("error marker did not set flag");
   count_up_a: assert property (@(posedge hclk) disable iff (!hresetn)      // [RQ11]
      run_w && up_w && !dn_w |=> up_down_counter_q == $past(up_down_counter_q) + 8'h01)
      else $error("counter did not increment");
   count_both_a: assert property (@(posedge hclk) disable iff (!hresetn)    // [RQ11]
      run_w && up_w && dn_w |=> $stable(up_down_counter_q))
      else $error("counter moved with both markers");
   env_no_step_a: assert property (@(posedge hclk) disable iff (!hresetn)   // [RQ7]
      env_w && run_w |=> $stable(p.state))
      else $error("decoder stepped in envelope test");
   common_ref_a: assert property (@(posedge hclk) disable iff (!hresetn)    // [RQ8]
      ctrl_q[SQD_CTRL_COMMON] && $stable(ref_a_q) |=> out_ref_b_q == out_ref_a_q)
      else $error("common input did not share reference");
   divider_off_a: assert property (@(posedge hclk) disable iff (!hresetn)   // [RQ9]
      $rose(div_q) && !start_w ##1 !start_w [*7] |-> ##[1:30] !div_q || start_w)
      else $error("divider stayed on after settling");
   osc_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)      // [RQ6]
      comp_w[0] && !step_w |=> osc_latch_q[0])
      else $error("oscillation pulse not held");
   cover_up_c: cover property (@(posedge hclk) disable iff (!hresetn) up_w && !dn_w);
   cover_err_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(err_flag_q));
   cover_env_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(cap_a_q));
endmodule // sqd_top

// ==== testbench/sqd_sensor_model.sv ====
// behavioural rotation sensors and scan sequencer behind the comparator pins
`timescale 1ns/10ps
module sqd_sensor_model (
   // clock
   input  wire logic hclk,
   // comparator and sequence pins
   output logic      comp_a_pin,
   output logic      comp_b_pin,
   output logic      seq_start_pin,
   output logic      seq_end_pin
);
   import sqd_pkg::*;
   initial begin
      comp_a_pin    = 1'b0;
      comp_b_pin    = 1'b0;
      seq_start_pin = 1'b0;
      seq_end_pin   = 1'b0;
   end
   // steady comparator levels, used for the envelope test
   task automatic set_level(input logic [1:0] pair);
      @(posedge hclk);
      comp_a_pin <= pair[0];
      comp_b_pin <= pair[1];
   endtask
   // one frame; osc toggles the high results early in the frame only
   task automatic scan(input logic [1:0] pair, input bit osc);
      logic t;
      @(posedge hclk);
      seq_start_pin <= 1'b1;
      for (int i = 0; i < SQD_SETTLE_CYC + 8; i++) begin
         @(posedge hclk);
         t = !osc || (i[0] && i < 12);
         comp_a_pin <= pair[0] & t;
         comp_b_pin <= pair[1] & t;
         if (i == 4) seq_end_pin <= 1'b1;
      end
      @(posedge hclk);
      seq_end_pin   <= 1'b0;
      seq_start_pin <= 1'b0;
      repeat (8) @(posedge hclk);
      comp_a_pin <= 1'b0;
      comp_b_pin <= 1'b0;
      repeat (4) @(posedge hclk);
   endtask
endmodule // sqd_sensor_model

// ==== testbench/test_scan_quadrature_decoder.sv ====
// self-checking bench for the quadrature decoder top
`timescale 1ns/10ps
module test_scan_quadrature_decoder;
   import sqd_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [2:0]  hsize;
   logic [1:0]  htrans, prev;
   logic        comp_a_pin, comp_b_pin, seq_start_pin, seq_end_pin;
   logic [7:0]  ref_level_a, ref_level_b, exp_state, exp_cnt;
   logic        capture_a, capture_b, divider_on, error_state_flag;
   logic [1:0]  walk [16] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h0, 2'h3, 2'h1, 2'h1,
                              2'h2, 2'h1, 2'h3, 2'h2, 2'h2, 2'h3, 2'h3, 2'h0};
   int          fail_count = 0;
   int          n_checks = 0;

   sqd_top sqd_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .comp_a_pin(comp_a_pin),
      .comp_b_pin(comp_b_pin), .seq_start_pin(seq_start_pin), .seq_end_pin(seq_end_pin),
      .ref_level_a(ref_level_a), .ref_level_b(ref_level_b), .capture_a(capture_a),
      .capture_b(capture_b), .divider_on(divider_on), .error_state_flag(error_state_flag));
   sqd_sensor_model sqd_sensor_model_i (.hclk(hclk), .comp_a_pin(comp_a_pin),
      .comp_b_pin(comp_b_pin), .seq_start_pin(seq_start_pin), .seq_end_pin(seq_end_pin));

   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // one single ahb-lite transfer; waits on hready in both phases
   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h000000, a};
      hwrite <= w;
      hsize  <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
      ahb(a, 1'b0, 32'h0);
      check(rd, exp, what);
   endtask

   function automatic logic [7:0] next_state(input logic [1:0] p, input logic [1:0] c);
      logic inc, dec, err;
      inc = (p == 2'b00) && (c == 2'b01);
      dec = (p == 2'b00) && (c == 2'b10);
      err = (p ^ c) == 2'b11;
      return {1'b0, err, 2'b00, c[1], dec, inc, c[0]};
   endfunction

   // one evaluation followed by a readback of state, index, count and flag
   task automatic step(input logic [1:0] c, input bit osc, input logic [7:0] ctrl);
      logic [7:0] s;
      s = next_state(prev, c);
      if (s[1] && ctrl[1]) exp_cnt++;
      if (s[2] && ctrl[2]) exp_cnt--;
      prev = c;
      sqd_sensor_model_i.scan(c, osc);
      ahb(SQD_OFF_STATUS, 1'b0, 32'h0);
      check(rd[15:8], s, "state byte");
      check(rd[23:16], {1'b0, ctrl[3] & s[6], s[5:3], s[0], 2'b00}, "next index");
      check(rd[0], s[6], "error flag bit");
      check(error_state_flag, s[6], "error flag pin");
      rdc(SQD_OFF_COUNT, {24'h0, exp_cnt}, "counter");
      if (s[6]) begin
         ahb(SQD_OFF_STATUS, 1'b1, 32'h1);
         @(posedge hclk);
         check(error_state_flag, 1'b0, "flag cleared");
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge hclk);
      fail_count++;
      $display("wrong value at %0t: watchdog expired", $time);
      end_sim();
   end

   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, htrans, haddr, hwdata, hsize} = '0;
      exp_cnt = 8'h00;
      prev    = 2'b00;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      check({capture_a, capture_b, divider_on, error_state_flag}, 4'h0, "pins");
      rdc(SQD_OFF_CTRL, 32'h0, "ctrl reset");
      rdc(SQD_OFF_STATUS, 32'h0, "status reset");
      rdc(SQD_OFF_COUNT, 32'h0, "count reset");
      rdc(SQD_OFF_REF, 32'h0, "ref reset");
      ahb(8'h10, 1'b1, 32'hFFFFFFFF);
      rdc(8'h10, 32'h0, "unmapped");
      ahb(SQD_OFF_COUNT, 1'b1, 32'h000000FF);
      rdc(SQD_OFF_COUNT, 32'h0, "count read only");
      $display("test reset done");
      ahb(SQD_OFF_REF, 1'b1, 32'h0000B45A);
      repeat (2) @(posedge hclk);
      check({ref_level_b, ref_level_a}, 16'hB45A, "per sensor refs");
      ahb(SQD_OFF_CTRL, 1'b1, 32'h80);
      repeat (2) @(posedge hclk);
      check({ref_level_b, ref_level_a}, 16'h5A5A, "common ref");
      $display("test reference done");
      ahb(SQD_OFF_CTRL, 1'b1, 32'h2F);
      fork
         step(walk[0], 1'b0, 8'h2F);
         begin
            repeat (8) @(posedge hclk);
            check(divider_on, 1'b1, "divider on");
            repeat (SQD_SETTLE_CYC + 2) @(posedge hclk);
            check(divider_on, 1'b0, "divider off");
         end
      join
      for (int i = 1; i < 16; i++) step(walk[i], 1'b0, 8'h2F);
      ahb(SQD_OFF_CTRL, 1'b1, 32'h29);
      for (int i = 0; i < 4; i++) step(i[0] ? 2'b00 : 2'b01 + i[1], 1'b0, 8'h29);
      $display("test table walk done");
      ahb(SQD_OFF_CTRL, 1'b1, 32'h0);
      exp_cnt = 8'h00;
      prev    = 2'b00;
      ahb(SQD_OFF_CTRL, 1'b1, 32'h07);
      for (int i = 0; i < 4; i++) step(i[0] ? 2'b00 : 2'b01 + i[1], 1'b1, 8'h07);
      $display("test oscillation done");
      ahb(SQD_OFF_CTRL, 1'b1, 32'h43);
      sqd_sensor_model_i.set_level(2'b01);
      repeat (6) @(posedge hclk);
      check({capture_b, capture_a}, 2'b01, "capture a");
      sqd_sensor_model_i.set_level(2'b10);
      repeat (6) @(posedge hclk);
      check({capture_b, capture_a}, 2'b10, "capture b");
      sqd_sensor_model_i.scan(2'b11, 1'b0);
      ahb(SQD_OFF_STATUS, 1'b0, 32'h0);
      check(rd[15:0], 16'h0000, "no step in envelope");
      rdc(SQD_OFF_COUNT, {24'h0, exp_cnt}, "no count in envelope");
      ahb(SQD_OFF_CTRL, 1'b1, 32'h23);
      sqd_sensor_model_i.set_level(2'b11);
      repeat (6) @(posedge hclk);
      check({capture_b, capture_a}, 2'b00, "capture off");
      sqd_sensor_model_i.set_level(2'b00);
      $display("test envelope done");
      end_sim();
   end
endmodule // test_scan_quadrature_decoder
